// file: rtl/uec_pkg.sv
// Package of constants and types for the USB endpoint control block
`default_nettype none
package uec_pkg;
  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_CTL = 6'h22;
  localparam logic [5:0] IDX_CNT0RX = 6'h26;
  localparam logic [5:0] IDX_CNT0TX = 6'h27;
  localparam logic [5:0] IDX_EP1TX = 6'h28;
  localparam logic [5:0] IDX_CNT1TX = 6'h29;
  localparam logic [5:0] IDX_EP2RX = 6'h2A;
  localparam logic [5:0] IDX_CNT2RX = 6'h2B;
  localparam logic [5:0] IDX_EP2TX = 6'h2C;
  localparam logic [5:0] IDX_CNT2TX = 6'h2D;
  localparam logic [5:0] IDX_EP3TX = 6'h2E;
  localparam logic [5:0] IDX_CNT3TX = 6'h2F;
  localparam logic [5:0] IDX_EP4TX = 6'h30;
  localparam logic [5:0] IDX_CNT4TX = 6'h31;
  localparam logic [5:0] IDX_EP5TX = 6'h32;
  localparam logic [5:0] IDX_CNT5TX = 6'h33;
  localparam logic [5:0] IDX_ISR = 6'h38;
  localparam logic [5:0] IDX_IMR = 6'h39;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;
  // ****************************************
  // Field layout
  // ****************************************
  localparam int STAT_LSB = 0;
  localparam int STAT_MSB = 1;
  localparam int TOG_BIT = 2;
  localparam int DONE_BIT = 3;
  localparam int FORCE_BUS_RESET_BIT = 0;
  localparam logic [3:0] UPPER_ZERO = 4'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************************************
  // Status encodings and handshakes
  // ****************************************
  localparam logic [1:0] ST_DIS = 2'h0;
  localparam logic [1:0] ST_STALL = 2'h1;
  localparam logic [1:0] ST_NAK = 2'h2;
  localparam logic [1:0] ST_VALID = 2'h3;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_DATA = 2'h3;
  // ****************************************
  // Counters, endpoints, interrupts
  // ****************************************
  localparam logic [6:0] CNT_NARROW = 7'h0F;
  localparam logic [6:0] CNT_WIDE = 7'h7F;
  localparam logic [6:0] CNT_ZERO = 7'h00;
  localparam logic [6:0] CNT_ONE = 7'h01;
  localparam logic [2:0] EP0 = 3'h0;
  localparam logic [2:0] EP2 = 3'h2;
  localparam int INT_W = 5;
  localparam int INT_TX = 0;
  localparam int INT_RX = 1;
  localparam int INT_SETUP = 2;
  localparam int INT_STALL = 3;
  localparam int INT_RST = 4;
  typedef enum logic [1:0] {PH_IDLE, PH_IN_WAIT, PH_RX} uec_phase_type;
endpackage
`default_nettype wire

// file: rtl/uec_top.sv
// Endpoint status, toggle and byte count logic for USB endpoints
`default_nettype none
module uec_top
  import uec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic force_bus_reset,
  input wire logic bus_reset,
  input wire logic in_token,
  input wire logic out_token,
  input wire logic setup_token,
  input wire logic [2:0] tok_ep,
  input wire logic host_ack,
  input wire logic rx_byte,
  input wire logic rx_end,
  input wire logic rx_ok,
  input wire logic rx_data1,
  output logic byte_store,
  output logic hs_valid,
  output logic [1:0] hs_code,
  output logic [6:0] tx_len,
  output logic tx_data1
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [5:0] tx_ctl_idx(input int e);
    case (e)
      1: tx_ctl_idx = IDX_EP1TX;
      2: tx_ctl_idx = IDX_EP2TX;
      3: tx_ctl_idx = IDX_EP3TX;
      4: tx_ctl_idx = IDX_EP4TX;
      default: tx_ctl_idx = IDX_EP5TX;
    endcase
  endfunction

  function automatic logic [5:0] tx_cnt_idx(input int e);
    case (e)
      0: tx_cnt_idx = IDX_CNT0TX;
      1: tx_cnt_idx = IDX_CNT1TX;
      2: tx_cnt_idx = IDX_CNT2TX;
      3: tx_cnt_idx = IDX_CNT3TX;
      4: tx_cnt_idx = IDX_CNT4TX;
      default: tx_cnt_idx = IDX_CNT5TX;
    endcase
  endfunction

  function automatic logic [6:0] cnt_mask(input int e);
    cnt_mask = (e == 2) ? CNT_WIDE : CNT_NARROW;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0] tx_stat_q [1:5];
  logic tx_tog_q [1:5];
  logic tx_done_q [1:5];
  logic [6:0] tx_cnt_q [0:5];
  logic [7:0] tx_ctl_rd [1:5];
  logic [5:1] ack_ep;
  logic [5:1] setup_ep;
  logic [5:1] stall_ep;
  logic [1:0] rx_stat_q;
  logic rx_tog_q;
  logic rx_done_q;
  logic [3:0] rx0_cnt_q;
  logic [6:0] rx2_cnt_q;
  logic ctl_force_bus_reset_q;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] int_ev;
  logic usb_rst;
  logic usb_rst_prev_q;
  uec_phase_type phase_q;
  logic [2:0] cur_ep_q;
  logic cur_setup_q;
  logic store_ok_q;
  logic wr_ok;
  logic [5:0] idx;
  logic rx2_setup;
  logic rx2_stall;
  logic rx_good;
  logic budget_left;
  logic [7:0] rd_val;
  logic [7:0] rdata_q;
  logic hs_valid_q;
  logic [1:0] hs_code_q;
  logic [6:0] tx_len_q;
  logic tx_data1_q;

  assign idx = reg_addr[7:2];
  assign wr_ok = reg_wr && (reg_addr[1:0] == ADDR_ALIGN);
  assign usb_rst = bus_reset || ctl_force_bus_reset_q;
  assign force_bus_reset = ctl_force_bus_reset_q;

  // ****************************************
  // Receive side events for endpoint 2
  // ****************************************
  assign rx2_setup = setup_token && (tok_ep == EP2) &&
                     (rx_stat_q != ST_DIS || tx_stat_q[2] != ST_DIS);
  assign rx2_stall = rx_end && (phase_q == PH_RX) && (cur_ep_q == EP2) &&
                     !cur_setup_q && (rx_stat_q == ST_STALL);
  assign rx_good = rx_end && (phase_q == PH_RX) && (cur_ep_q == EP2) &&
                   !cur_setup_q && rx_ok && (rx_stat_q == ST_VALID) &&
                   (rx_data1 == rx_tog_q);

  // ****************************************
  // Transmit endpoints 1 to 5
  // ****************************************
  for (genvar e = 1; e <= 5; e++) begin : g_tx
    logic sel;
    logic wr_here;
    assign sel = (tok_ep == 3'(e));
    assign wr_here = wr_ok && (idx == tx_ctl_idx(e));
    assign ack_ep[e] = host_ack && (phase_q == PH_IN_WAIT) &&
                       (cur_ep_q == 3'(e));
    assign setup_ep[e] = (e == 2) ? rx2_setup :
                         (setup_token && sel && tx_stat_q[e] != ST_DIS);
    assign stall_ep[e] = (in_token && sel && tx_stat_q[e] == ST_STALL) ||
                         ((e == 2) && rx2_stall);
    assign tx_ctl_rd[e] = {UPPER_ZERO, tx_done_q[e], tx_tog_q[e],
                           tx_stat_q[e]};

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        tx_stat_q[e] <= ST_DIS;
      end else if (usb_rst) begin
        tx_stat_q[e] <= ST_DIS;
      end else if (stall_ep[e]) begin
        tx_stat_q[e] <= ST_STALL;
      end else if (setup_ep[e]) begin
        tx_stat_q[e] <= ST_NAK;
      end else if (ack_ep[e]) begin
        tx_stat_q[e] <= ST_NAK;
      end else if (wr_here) begin
        tx_stat_q[e] <= reg_wdata[STAT_MSB:STAT_LSB];
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        tx_tog_q[e] <= 1'b0;
      end else if (usb_rst) begin
        tx_tog_q[e] <= 1'b0;
      end else if (ack_ep[e]) begin
        tx_tog_q[e] <= ~tx_tog_q[e];
      end else if (wr_here) begin
        tx_tog_q[e] <= reg_wdata[TOG_BIT];
      end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        tx_done_q[e] <= 1'b0;
      end else if (ack_ep[e]) begin
        tx_done_q[e] <= 1'b1;
      end else if (wr_here && !reg_wdata[DONE_BIT]) begin
        tx_done_q[e] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit byte counts, endpoints 0 to 5
  // ****************************************
  for (genvar c = 0; c <= 5; c++) begin : g_cnt
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        tx_cnt_q[c] <= CNT_ZERO;
      end else if (wr_ok && idx == tx_cnt_idx(c)) begin
        tx_cnt_q[c] <= reg_wdata[6:0] & cnt_mask(c);
      end
    end
  end

  // ****************************************
  // Endpoint 2 receive control
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_stat_q <= ST_DIS;
    end else if (usb_rst) begin
      rx_stat_q <= ST_DIS;
    end else if (stall_ep[2]) begin
      rx_stat_q <= ST_STALL;
    end else if (rx2_setup) begin
      rx_stat_q <= ST_NAK;
    end else if (rx_good) begin
      rx_stat_q <= ST_NAK;
    end else if (wr_ok && idx == IDX_EP2RX) begin
      rx_stat_q <= reg_wdata[STAT_MSB:STAT_LSB];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_tog_q <= 1'b0;
    end else if (usb_rst) begin
      rx_tog_q <= 1'b0;
    end else if (rx_good) begin
      rx_tog_q <= ~rx_tog_q;
    end else if (wr_ok && idx == IDX_EP2RX) begin
      rx_tog_q <= reg_wdata[TOG_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_done_q <= 1'b0;
    end else if (rx_good) begin
      rx_done_q <= 1'b1;
    end else if (wr_ok && idx == IDX_EP2RX && !reg_wdata[DONE_BIT]) begin
      rx_done_q <= 1'b0;
    end
  end

  // ****************************************
  // Receive budgets
  // ****************************************
  assign budget_left = (cur_ep_q == EP0) ? (rx0_cnt_q != 4'h0) :
                       (rx2_cnt_q != CNT_ZERO);
  assign byte_store = rx_byte && (phase_q == PH_RX) && store_ok_q &&
                      budget_left;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx0_cnt_q <= 4'h0;
    end else if (byte_store && cur_ep_q == EP0) begin
      rx0_cnt_q <= rx0_cnt_q - 4'h1;
    end else if (wr_ok && idx == IDX_CNT0RX) begin
      rx0_cnt_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx2_cnt_q <= CNT_ZERO;
    end else if (byte_store && cur_ep_q == EP2) begin
      rx2_cnt_q <= rx2_cnt_q - CNT_ONE;
    end else if (wr_ok && idx == IDX_CNT2RX) begin
      rx2_cnt_q <= reg_wdata[6:0] & CNT_WIDE;
    end
  end

  // ****************************************
  // Transaction phase
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      cur_ep_q <= EP0;
      cur_setup_q <= 1'b0;
      store_ok_q <= 1'b0;
    end else if (usb_rst) begin
      phase_q <= PH_IDLE;
    end else if (in_token) begin
      cur_ep_q <= tok_ep;
      if (tok_ep != EP0 && tok_ep <= 3'h5 &&
          tx_stat_q[tok_ep] == ST_VALID) begin
        phase_q <= PH_IN_WAIT;
      end else begin
        phase_q <= PH_IDLE;
      end
    end else if (out_token || setup_token) begin
      cur_ep_q <= tok_ep;
      cur_setup_q <= setup_token;
      store_ok_q <= (tok_ep == EP0) || setup_token ||
                    (rx_stat_q == ST_VALID);
      if (tok_ep == EP0 || rx2_setup ||
          (tok_ep == EP2 && rx_stat_q != ST_DIS)) begin
        phase_q <= PH_RX;
      end else begin
        phase_q <= PH_IDLE;
      end
    end else begin
      case (phase_q)
        PH_IN_WAIT: begin
          if (host_ack) begin
            phase_q <= PH_IDLE;
          end
        end
        PH_RX: begin
          if (rx_end) begin
            phase_q <= PH_IDLE;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // ****************************************
  // Handshake and IN packet answer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_valid_q <= 1'b0;
      hs_code_q <= HS_ACK;
      tx_len_q <= CNT_ZERO;
      tx_data1_q <= 1'b0;
    end else begin
      hs_valid_q <= 1'b0;
      if (usb_rst) begin
        hs_valid_q <= 1'b0;
      end else if (in_token && tok_ep != EP0 && tok_ep <= 3'h5) begin
        tx_len_q <= tx_cnt_q[tok_ep];
        tx_data1_q <= tx_tog_q[tok_ep];
        hs_valid_q <= (tx_stat_q[tok_ep] != ST_DIS);
        case (tx_stat_q[tok_ep])
          ST_STALL: hs_code_q <= HS_STALL;
          ST_NAK: hs_code_q <= HS_NAK;
          default: hs_code_q <= HS_DATA;
        endcase
      end else if (rx_end && phase_q == PH_RX && rx_ok) begin
        hs_valid_q <= 1'b1;
        if (cur_setup_q || cur_ep_q == EP0) begin
          hs_code_q <= HS_ACK;
        end else begin
          case (rx_stat_q)
            ST_STALL: hs_code_q <= HS_STALL;
            ST_NAK: hs_code_q <= HS_NAK;
            default: hs_code_q <= HS_ACK;
          endcase
        end
      end
    end
  end

  assign hs_valid = hs_valid_q;
  assign hs_code = hs_code_q;
  assign tx_len = tx_len_q;
  assign tx_data1 = tx_data1_q;

  // ****************************************
  // Interface control, interrupts
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_force_bus_reset_q <= 1'b0;
      int_mask_q <= '0;
      usb_rst_prev_q <= 1'b0;
    end else begin
      usb_rst_prev_q <= usb_rst;
      if (wr_ok && idx == IDX_CTL) begin
        ctl_force_bus_reset_q <= reg_wdata[FORCE_BUS_RESET_BIT];
      end
      if (wr_ok && idx == IDX_IMR) begin
        int_mask_q <= reg_wdata[INT_W-1:0];
      end
    end
  end

  assign int_ev[INT_TX] = |ack_ep;
  assign int_ev[INT_RX] = rx_good;
  assign int_ev[INT_SETUP] = |setup_ep;
  assign int_ev[INT_STALL] = |stall_ep;
  assign int_ev[INT_RST] = usb_rst && !usb_rst_prev_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_stat_q <= '0;
    end else if (wr_ok && idx == IDX_ISR) begin
      int_stat_q <= (int_stat_q & ~reg_wdata[INT_W-1:0]) | int_ev;
    end else begin
      int_stat_q <= int_stat_q | int_ev;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_val = REG_RESET;
    if (reg_addr[1:0] == ADDR_ALIGN) begin
      case (idx)
        IDX_CTL: rd_val = {7'h00, ctl_force_bus_reset_q};
        IDX_CNT0RX: rd_val = {UPPER_ZERO, rx0_cnt_q};
        IDX_CNT0TX: rd_val = {1'b0, tx_cnt_q[0]};
        IDX_EP1TX: rd_val = tx_ctl_rd[1];
        IDX_CNT1TX: rd_val = {1'b0, tx_cnt_q[1]};
        IDX_EP2RX: rd_val = {UPPER_ZERO, rx_done_q, rx_tog_q, rx_stat_q};
        IDX_CNT2RX: rd_val = {1'b0, rx2_cnt_q};
        IDX_EP2TX: rd_val = tx_ctl_rd[2];
        IDX_CNT2TX: rd_val = {1'b0, tx_cnt_q[2]};
        IDX_EP3TX: rd_val = tx_ctl_rd[3];
        IDX_CNT3TX: rd_val = {1'b0, tx_cnt_q[3]};
        IDX_EP4TX: rd_val = tx_ctl_rd[4];
        IDX_CNT4TX: rd_val = {1'b0, tx_cnt_q[4]};
        IDX_EP5TX: rd_val = tx_ctl_rd[5];
        IDX_CNT5TX: rd_val = {1'b0, tx_cnt_q[5]};
        IDX_ISR: rd_val = {3'h0, int_stat_q};
        IDX_IMR: rd_val = {3'h0, int_mask_q};
        default: rd_val = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= REG_RESET;
    end else begin
      rdata_q <= reg_rd ? rd_val : REG_RESET;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_setup_nak;
    @(posedge sys_clk) disable iff (rst)
    setup_token && tok_ep == 3'h1 && tx_stat_q[1] != ST_DIS && !usb_rst
    |=> tx_stat_q[1] == ST_NAK;
  endproperty
  a_setup_nak: assert property (p_setup_nak)
    else $error("setup did not force NAK");

  property p_stall_both;
    @(posedge sys_clk) disable iff (rst)
    in_token && tok_ep == EP2 && tx_stat_q[2] == ST_STALL && !usb_rst
    |=> rx_stat_q == ST_STALL && hs_valid && hs_code == HS_STALL;
  endproperty
  a_stall_both: assert property (p_stall_both)
    else $error("stall did not reach both fields");

  property p_rst_tx;
    @(posedge sys_clk) disable iff (rst)
    usb_rst |=> tx_stat_q[3] == ST_DIS && !tx_tog_q[3];
  endproperty
  a_rst_tx: assert property (p_rst_tx)
    else $error("transmit control not cleared by USB reset");

  property p_rst_rx;
    @(posedge sys_clk) disable iff (rst)
    usb_rst |=> rx_stat_q == ST_DIS && !rx_tog_q && !hs_valid;
  endproperty
  a_rst_rx: assert property (p_rst_rx)
    else $error("receive control not cleared by USB reset");

  property p_upper_zero;
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == {IDX_EP4TX, ADDR_ALIGN}
    |=> reg_rdata[7:4] == UPPER_ZERO &&
        reg_rdata[STAT_MSB:STAT_LSB] == $past(tx_stat_q[4]);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("control read upper bits not zero");

  property p_tx_ack;
    @(posedge sys_clk) disable iff (rst)
    ack_ep[1] && !usb_rst |=> tx_done_q[1] && tx_stat_q[1] == ST_NAK &&
                              tx_tog_q[1] != $past(tx_tog_q[1]);
  endproperty
  a_tx_ack: assert property (p_tx_ack)
    else $error("ACK did not finish transmit transfer");

  property p_rx_good;
    @(posedge sys_clk) disable iff (rst)
    rx_good && !usb_rst |=> rx_done_q && rx_stat_q == ST_NAK &&
                            rx_tog_q != $past(rx_tog_q);
  endproperty
  a_rx_good: assert property (p_rx_good)
    else $error("good reception not recorded");

  property p_budget;
    @(posedge sys_clk) disable iff (rst)
    byte_store && cur_ep_q == EP2 |=> rx2_cnt_q == $past(rx2_cnt_q) - CNT_ONE;
  endproperty
  a_budget: assert property (p_budget)
    else $error("budget did not count down");

  property p_no_wrap;
    @(posedge sys_clk) disable iff (rst)
    rx_byte && phase_q == PH_RX && cur_ep_q == EP0 && rx0_cnt_q == 4'h0
    |-> !byte_store ##1 rx0_cnt_q == 4'h0;
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("budget wrapped or byte stored past budget");

  property p_in_len;
    @(posedge sys_clk) disable iff (rst)
    in_token && tok_ep == 3'h3 && tx_stat_q[3] == ST_VALID && !usb_rst
    |=> hs_code == HS_DATA && tx_len == $past(tx_cnt_q[3]);
  endproperty
  a_in_len: assert property (p_in_len)
    else $error("IN answer length wrong");
endmodule
`default_nettype wire

// file: bench/uec_host.sv
// Host model issuing tokens, data packets and handshakes
`default_nettype none
module uec_host (
  input wire logic sys_clk,
  input wire logic byte_store,
  output logic in_token,
  output logic out_token,
  output logic setup_token,
  output logic [2:0] tok_ep,
  output logic host_ack,
  output logic rx_byte,
  output logic rx_end,
  output logic rx_ok,
  output logic rx_data1
);
  timeunit 1ns;
  timeprecision 1ps;
  int stored;
  initial begin
    in_token = 1'b0;
    out_token = 1'b0;
    setup_token = 1'b0;
    tok_ep = 3'h7;
    host_ack = 1'b0;
    rx_byte = 1'b0;
    rx_end = 1'b0;
    rx_ok = 1'b0;
    rx_data1 = 1'b0;
  end
  // ****************************************
  // Transaction tasks
  // ****************************************
  // Token pulse, kind 0 IN, 1 OUT, 2 SETUP
  task automatic token(input int kind, input logic [2:0] ep);
    @(posedge sys_clk);
    in_token <= (kind == 0);
    out_token <= (kind == 1);
    setup_token <= (kind == 2);
    tok_ep <= ep;
    @(posedge sys_clk);
    in_token <= 1'b0;
    out_token <= 1'b0;
    setup_token <= 1'b0;
    tok_ep <= ~ep;
  endtask
  // Handshake after a chosen delay
  task automatic ack(input int gap);
    repeat (gap + 1) @(posedge sys_clk);
    host_ack <= 1'b1;
    @(posedge sys_clk);
    host_ack <= 1'b0;
  endtask
  // Data packet, counts bytes taken
  task automatic packet(input int n, input logic ok, input logic d1);
    stored = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_byte <= 1'b1;
      #1;
      stored += int'(byte_store);
    end
    @(posedge sys_clk);
    rx_byte <= 1'b0;
    rx_end <= 1'b1;
    rx_ok <= ok;
    rx_data1 <= d1;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    rx_ok <= ~ok;
    rx_data1 <= ~d1;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the endpoint control block
`default_nettype none
module tb_top
  import uec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bus_reset = 1'b0;
  logic [7:0] reg_rdata;
  logic irq, force_bus_reset, byte_store, hs_valid, tx_data1;
  logic in_token, out_token, setup_token, host_ack;
  logic rx_byte, rx_end, rx_ok, rx_data1;
  logic [2:0] tok_ep;
  logic [1:0] hs_code;
  logic [6:0] tx_len;
  logic [1:0] hs_map [4] = '{HS_ACK, HS_STALL, HS_NAK, HS_DATA};
  int err_total = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  uec_top dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .force_bus_reset(force_bus_reset),
    .bus_reset(bus_reset), .in_token(in_token), .out_token(out_token),
    .setup_token(setup_token), .tok_ep(tok_ep), .host_ack(host_ack),
    .rx_byte(rx_byte), .rx_end(rx_end), .rx_ok(rx_ok),
    .rx_data1(rx_data1), .byte_store(byte_store), .hs_valid(hs_valid),
    .hs_code(hs_code), .tx_len(tx_len), .tx_data1(tx_data1)
  );
  uec_host host_u (
    .sys_clk(sys_clk), .byte_store(byte_store), .in_token(in_token),
    .out_token(out_token), .setup_token(setup_token), .tok_ep(tok_ep),
    .host_ack(host_ack), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_ok(rx_ok), .rx_data1(rx_data1)
  );
  // ****************************************
  // Check and bus tasks
  // ****************************************
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= {idx, ADDR_ALIGN};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd({idx, ADDR_ALIGN}, v);
    chk("reg", v, exp);
  endtask
  task automatic hc(input logic v, input logic [1:0] code);
    #1;
    chk("hs", {5'h00, hs_valid, hs_code}, {5'h00, v, code});
  endtask
  task automatic ic(input logic e);
    #1;
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rc(IDX_EP1TX, REG_RESET);
    rc(IDX_EP2RX, REG_RESET);
    rc(IDX_EP4TX, REG_RESET);
    $display("test reset done");
    wr(IDX_EP1TX, 8'h03);
    wr(IDX_CNT1TX, 8'h05);
    wr(IDX_IMR, 8'h01);
    host_u.token(0, 3'h1);
    hc(1'b1, HS_DATA);
    chk("len", {1'b0, tx_len}, 8'h05);
    chk("pid", {7'h00, tx_data1}, 8'h00);
    host_u.ack(2);
    rc(IDX_EP1TX, 8'h0E);
    ic(1'b1);
    wr(IDX_IMR, 8'h00);
    ic(1'b0);
    wr(IDX_ISR, 8'h01);
    wr(IDX_IMR, 8'h01);
    ic(1'b0);
    wr(IDX_EP1TX, 8'hF7);
    rc(IDX_EP1TX, 8'h07);
    host_u.token(0, 3'h1);
    hc(1'b1, HS_DATA);
    chk("pid", {7'h00, tx_data1}, 8'h01);
    host_u.ack(0);
    rc(IDX_EP1TX, 8'h0A);
    wr(IDX_EP1TX, 8'h0B);
    host_u.token(2, 3'h1);
    rc(IDX_EP1TX, 8'h0A);
    $display("test transmit done");
    for (int s = 0; s < 4; s++) begin
      wr(IDX_EP3TX, 8'(s));
      host_u.token(0, 3'h3);
      #1;
      chk("hsv", {7'h00, hs_valid}, {7'h00, s != 0});
      if (s != 0) chk("hsc", {6'h00, hs_code}, {6'h00, hs_map[s]});
    end
    $display("test status done");
    wr(IDX_EP2RX, 8'h03);
    wr(IDX_CNT2RX, 8'h08);
    wr(IDX_IMR, 8'h02);
    host_u.token(1, 3'h2);
    host_u.packet(3, 1'b1, 1'b0);
    hc(1'b1, HS_ACK);
    chk("stored", 8'(host_u.stored), 8'h03);
    rc(IDX_EP2RX, 8'h0E);
    rc(IDX_CNT2RX, 8'h05);
    ic(1'b1);
    wr(IDX_EP2RX, 8'h07);
    host_u.token(1, 3'h2);
    host_u.packet(1, 1'b1, 1'b0);
    hc(1'b1, HS_ACK);
    rc(IDX_EP2RX, 8'h07);
    wr(IDX_CNT2RX, 8'h02);
    host_u.token(1, 3'h2);
    host_u.packet(3, 1'b1, 1'b1);
    chk("stored", 8'(host_u.stored), 8'h02);
    rc(IDX_CNT2RX, 8'h00);
    rc(IDX_EP2RX, 8'h0A);
    wr(IDX_EP2RX, 8'h01);
    wr(IDX_EP2TX, 8'h03);
    host_u.token(1, 3'h2);
    host_u.packet(1, 1'b1, 1'b0);
    hc(1'b1, HS_STALL);
    rc(IDX_EP2TX, 8'h01);
    rc(IDX_EP2RX, 8'h01);
    host_u.token(0, 3'h2);
    hc(1'b1, HS_STALL);
    rc(IDX_EP2RX, 8'h01);
    wr(IDX_EP2TX, 8'h03);
    wr(IDX_CNT2TX, 8'h45);
    host_u.token(0, 3'h2);
    hc(1'b1, HS_DATA);
    chk("len", {1'b0, tx_len}, 8'h45);
    wr(IDX_CNT0RX, 8'h04);
    host_u.token(2, 3'h0);
    host_u.packet(2, 1'b1, 1'b0);
    hc(1'b1, HS_ACK);
    rc(IDX_CNT0RX, 8'h02);
    host_u.token(1, 3'h0);
    host_u.packet(3, 1'b1, 1'b0);
    chk("stored", 8'(host_u.stored), 8'h02);
    rc(IDX_CNT0RX, 8'h00);
    $display("test receive done");
    wr(IDX_CTL, 8'h01);
    @(posedge sys_clk);
    #1;
    chk("frc", {7'h00, force_bus_reset}, 8'h01);
    wr(IDX_CTL, 8'h00);
    rc(IDX_EP1TX, 8'h08);
    rc(IDX_EP2RX, 8'h00);
    rd({IDX_ISR, ADDR_ALIGN}, v);
    chk("rstint", v & 8'h10, 8'h10);
    wr(IDX_EP3TX, 8'h07);
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    rc(IDX_EP3TX, 8'h00);
    rd(8'h89, v);
    chk("unmap", v, 8'h00);
    $display("test bus reset done");
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
